// >>> hdl/mbd_decode.sv
// Data order barrier decoder and ordering request issue
// Function
// - On a barrier the core orders observation of earlier against later accesses per the request.
// - Application and kernel level accesses are ordered only against the same virtual machine tag.
// - Hypervisor level accesses are ordered only against other hypervisor level accesses.
// - Options f, e and d give the full domain with all, writes-only and reads-before types.
// - Options b, a and 9 give the inner domain with all, writes-only and reads-before types.
// - Options 7, 6 and 5 give the local domain with all, writes-only and reads-before types.
// - Options 3, 2 and 1 give the outer domain with all, writes-only and reads-before types.
// - A writes-only barrier orders only writes before against writes after.
// - A reads-before barrier orders earlier reads against all later accesses, not earlier writes.
// - Reserved or unsupported options act as the full domain all-access barrier.
// - Only the full all-access option is mandatory; the others may be left unsupported.
// - With hypervisor present, non-secure, at application or kernel level, upgrade 11 forces full.
// - Under the same conditions, upgrade 10 raises any non-full domain to outer.
// - The fixed-width encoding only decodes with the always condition.
`timescale 1ns/1ps
`include "mbd_defs.svh"
module mbd_decode #(
  parameter int VM_TAG_W = 8,
  parameter logic [15:0] SUPPORTED_OPTS = `MBD_SUPPORT_ALL
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic compact_mode_i,
  input wire logic hyp_present_i,
  input wire logic secure_i,
  input wire logic [1:0] priv_level_i,
  input wire logic [1:0] hyp_barrier_upgrade_i,
  input wire logic [VM_TAG_W-1:0] virtual_machine_tag_i,
  input wire logic order_done_i,
  output logic barrier_req_o,
  output mbd_pkg::mbd_req_t barrier_info_o,
  output logic access_stall_o,
  output logic busy_o
);
  // The request carries an eight-bit tag field; other widths are refused with an elaboration error
  if (VM_TAG_W != 8) begin : g_tag_w_check
    $error("VM_TAG_W must match the request field width of 8");
  end

  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n = rst_s2_reg;

  // Opcode recognition
  wire wide_hit = ((instr_i & `MBD_WIDE_MASK) == `MBD_WIDE_MATCH);
  wire compact_hit = ((instr_i & `MBD_COMPACT_MASK) == `MBD_COMPACT_MATCH);
  // Barrier bits below the condition nibble, used to watch refused conditions
  wire wide_body = ((instr_i[27:0] & `MBD_WIDE_BODY_MASK) == `MBD_WIDE_BODY_MATCH);
  wire [3:0] cond_field = instr_i[31:28];
  // The fixed-width form lives in the unconditional space: no other condition decodes
  wire wide_ok = wide_hit && (cond_field == `MBD_COND_ALWAYS);
  wire is_barrier = instr_valid_i && (compact_mode_i ? compact_hit : wide_ok);
  wire [3:0] opt = instr_i[3:0];

  // Unsupported options fold into the full all-access barrier
  wire opt_supported = SUPPORTED_OPTS[opt] || (opt == `MBD_OPT_FULL_ALL);
  mbd_pkg::mbd_domain_t raw_dom;
  mbd_pkg::mbd_types_t raw_typ;
  always_comb begin
    raw_dom = mbd_pkg::MBD_DOM_FULL;
    raw_typ = mbd_pkg::MBD_TYP_ALL;
    if (opt_supported) begin
      unique case (opt)
        `MBD_OPT_FULL_WR: raw_typ = mbd_pkg::MBD_TYP_WRITES;
        `MBD_OPT_FULL_RD: raw_typ = mbd_pkg::MBD_TYP_READS;
        `MBD_OPT_INNER_ALL, `MBD_OPT_INNER_WR, `MBD_OPT_INNER_RD:
          raw_dom = mbd_pkg::MBD_DOM_INNER;
        `MBD_OPT_LOCAL_ALL, `MBD_OPT_LOCAL_WR, `MBD_OPT_LOCAL_RD:
          raw_dom = mbd_pkg::MBD_DOM_LOCAL;
        `MBD_OPT_OUTER_ALL, `MBD_OPT_OUTER_WR, `MBD_OPT_OUTER_RD:
          raw_dom = mbd_pkg::MBD_DOM_OUTER;
        default: raw_dom = mbd_pkg::MBD_DOM_FULL;
      endcase
      if (raw_dom != mbd_pkg::MBD_DOM_FULL) begin
        if (opt[1:0] == 2'h2) raw_typ = mbd_pkg::MBD_TYP_WRITES;
        if (opt[1:0] == 2'h1) raw_typ = mbd_pkg::MBD_TYP_READS;
      end
    end
  end

  // Hypervisor upgrade of the domain
  wire guest_level = (priv_level_i == `MBD_LVL_APP) || (priv_level_i == `MBD_LVL_KERNEL);
  wire upg_on = hyp_present_i && !secure_i && guest_level;
  wire upg_full = upg_on && (hyp_barrier_upgrade_i == `MBD_UPG_FULL);
  wire upg_outer = upg_on && (hyp_barrier_upgrade_i == `MBD_UPG_OUTER);
  mbd_pkg::mbd_domain_t fin_dom;
  always_comb begin
    fin_dom = raw_dom;
    if (upg_outer && raw_dom != mbd_pkg::MBD_DOM_FULL) fin_dom = mbd_pkg::MBD_DOM_OUTER;
    if (upg_full) fin_dom = mbd_pkg::MBD_DOM_FULL;
  end

  mbd_pkg::mbd_req_t req_next;
  always_comb begin
    req_next.domain = fin_dom;
    req_next.types = raw_typ;
    req_next.order_wr_before = (raw_typ != mbd_pkg::MBD_TYP_READS);
    req_next.order_rd_before = (raw_typ != mbd_pkg::MBD_TYP_WRITES);
    req_next.hyp_scope = (priv_level_i == `MBD_LVL_HYP);
    req_next.vm_tag = guest_level ? virtual_machine_tag_i : 8'h00;
  end

  // A new barrier is not taken while one is outstanding; the request is held until done
  logic busy_reg;
  logic req_reg;
  mbd_pkg::mbd_req_t info_reg;
  wire accept = is_barrier && !busy_reg;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      req_reg <= 1'b0;
      info_reg <= '0;
    end else begin
      if (accept) begin
        busy_reg <= 1'b1;
        req_reg <= 1'b1;
        info_reg <= req_next;
      end else if (busy_reg && order_done_i) begin
        busy_reg <= 1'b0;
        req_reg <= 1'b0;
      end
    end
  end
  assign barrier_req_o = req_reg;
  assign barrier_info_o = info_reg;
  assign access_stall_o = busy_reg;
  assign busy_o = busy_reg;

  // Request life: taken, held until the memory side answers, then released
  sequence held_s;
    barrier_req_o && access_stall_o && busy_o;
  endsequence
  sequence released_s;
    !barrier_req_o && !access_stall_o && !busy_o;
  endsequence
  sequence done_seen_s;
    busy_reg && order_done_i;
  endsequence

  full_upgrade_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && upg_full |=> barrier_info_o.domain == mbd_pkg::MBD_DOM_FULL)
    else $error("upgrade 11 did not force full domain");
  outer_upgrade_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && upg_outer && raw_dom != mbd_pkg::MBD_DOM_FULL
    |=> barrier_info_o.domain == mbd_pkg::MBD_DOM_OUTER)
    else $error("upgrade 10 did not raise to outer");
  reserved_full_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && (opt == 4'h0 || opt == 4'h4 || opt == 4'h8 || opt == 4'hc) && !upg_on
    |=> barrier_info_o.domain == mbd_pkg::MBD_DOM_FULL &&
        barrier_info_o.types == mbd_pkg::MBD_TYP_ALL)
    else $error("reserved option not full all");
  writes_only_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    barrier_req_o && barrier_info_o.types == mbd_pkg::MBD_TYP_WRITES
    |-> !barrier_info_o.order_rd_before && barrier_info_o.order_wr_before)
    else $error("writes-only barrier orders reads");
  reads_before_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    barrier_req_o && barrier_info_o.types == mbd_pkg::MBD_TYP_READS
    |-> barrier_info_o.order_rd_before && !barrier_info_o.order_wr_before)
    else $error("reads-before ordering wrong");
  cond_check_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    instr_valid_i && !compact_mode_i && wide_body && cond_field != `MBD_COND_ALWAYS &&
    !busy_reg |=> !barrier_req_o)
    else $error("conditional wide encoding was accepted");
  stall_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    barrier_req_o && !order_done_i |=> barrier_req_o && access_stall_o &&
    $stable(barrier_info_o))
    else $error("request dropped before ordering done");
  issue_seen_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept |=> barrier_req_o ##0 barrier_info_o.hyp_scope == $past(priv_level_i == 2'h2))
    else $error("barrier not issued");
  guest_tag_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && guest_level |=> barrier_info_o.vm_tag == $past(virtual_machine_tag_i))
    else $error("guest tag not carried");
  issue_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept |=> held_s)
    else $error("barrier not held after issue");
  release_done_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    done_seen_s |=> released_s)
    else $error("request still up after ordering done");
  quiet_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !busy_reg && !accept |=> !barrier_req_o)
    else $error("request raised with no barrier taken");
  hyp_scope_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && priv_level_i == `MBD_LVL_HYP
    |=> barrier_info_o.hyp_scope && barrier_info_o.vm_tag == 8'h00)
    else $error("hypervisor barrier not scoped to hypervisor");

  // Decode checks hold only for options this instance supports, with no upgrade active; the last checks unsupported options with any upgrade
  full_reads_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && !upg_on && opt == `MBD_OPT_FULL_RD && SUPPORTED_OPTS[`MBD_OPT_FULL_RD]
    |=> barrier_info_o.domain == mbd_pkg::MBD_DOM_FULL &&
        barrier_info_o.types == mbd_pkg::MBD_TYP_READS)
    else $error("full reads option decoded wrong");
  inner_all_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && !upg_on && opt == `MBD_OPT_INNER_ALL && SUPPORTED_OPTS[`MBD_OPT_INNER_ALL]
    |=> barrier_info_o.domain == mbd_pkg::MBD_DOM_INNER &&
        barrier_info_o.types == mbd_pkg::MBD_TYP_ALL)
    else $error("inner all option decoded wrong");
  local_writes_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && !upg_on && opt == `MBD_OPT_LOCAL_WR && SUPPORTED_OPTS[`MBD_OPT_LOCAL_WR]
    |=> barrier_info_o.domain == mbd_pkg::MBD_DOM_LOCAL &&
        barrier_info_o.types == mbd_pkg::MBD_TYP_WRITES)
    else $error("local writes option decoded wrong");
  outer_reads_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && !upg_on && opt == `MBD_OPT_OUTER_RD && SUPPORTED_OPTS[`MBD_OPT_OUTER_RD]
    |=> barrier_info_o.domain == mbd_pkg::MBD_DOM_OUTER &&
        barrier_info_o.types == mbd_pkg::MBD_TYP_READS)
    else $error("outer reads option decoded wrong");
  unsupported_opt_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && !SUPPORTED_OPTS[opt]
    |=> barrier_info_o.domain == mbd_pkg::MBD_DOM_FULL &&
        barrier_info_o.types == mbd_pkg::MBD_TYP_ALL)
    else $error("unsupported option not full all");
endmodule : mbd_decode

// >>> hdl/mbd_defs.svh
// Constants for the data order barrier decoder
`ifndef MBD_DEFS_SVH
`define MBD_DEFS_SVH
`define MBD_OPT_FULL_ALL 4'hf
`define MBD_OPT_FULL_WR 4'he
`define MBD_OPT_FULL_RD 4'hd
`define MBD_OPT_INNER_ALL 4'hb
`define MBD_OPT_INNER_WR 4'ha
`define MBD_OPT_INNER_RD 4'h9
`define MBD_OPT_LOCAL_ALL 4'h7
`define MBD_OPT_LOCAL_WR 4'h6
`define MBD_OPT_LOCAL_RD 4'h5
`define MBD_OPT_OUTER_ALL 4'h3
`define MBD_OPT_OUTER_WR 4'h2
`define MBD_OPT_OUTER_RD 4'h1
`define MBD_UPG_FULL 2'h3
`define MBD_UPG_OUTER 2'h2
`define MBD_COND_ALWAYS 4'hf
`define MBD_WIDE_BODY_MASK 28'hff0_fff0
`define MBD_WIDE_BODY_MATCH 28'h570_f050
`define MBD_LVL_APP 2'h0
`define MBD_LVL_KERNEL 2'h1
`define MBD_LVL_HYP 2'h2
`define MBD_WIDE_MASK 32'hfff0_fff0
`define MBD_WIDE_MATCH 32'hf570_f050
`define MBD_COMPACT_MASK 32'hfff0_fff0
`define MBD_COMPACT_MATCH 32'hf3b0_8f50
`define MBD_SUPPORT_ALL 16'hffff
`endif

// >>> hdl/mbd_pkg.sv
// Types for the data order barrier decoder
package mbd_pkg;
  typedef enum logic [1:0] {
    MBD_DOM_LOCAL,
    MBD_DOM_INNER,
    MBD_DOM_OUTER,
    MBD_DOM_FULL
  } mbd_domain_t;
  typedef enum logic [1:0] {
    MBD_TYP_ALL,
    MBD_TYP_WRITES,
    MBD_TYP_READS
  } mbd_types_t;
  typedef struct packed {
    mbd_domain_t domain;
    mbd_types_t types;
    logic order_wr_before;
    logic order_rd_before;
    logic hyp_scope;
    logic [7:0] vm_tag;
  } mbd_req_t;
endpackage : mbd_pkg

// >>> sim/mbd_mem_model.sv
// Memory system model that reports ordering done after a set delay
`timescale 1ns/1ps
module mbd_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic barrier_req_i,
  input wire logic [3:0] delay_i,
  output logic order_done_o
);
  logic [3:0] wait_reg;
  logic go;
  assign go = barrier_req_i && !order_done_o;
  // One pulse only, so a stale level can never release the next barrier
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg <= 4'h0;
      order_done_o <= 1'b0;
    end else begin
      order_done_o <= go && wait_reg == delay_i;
      wait_reg <= (go && wait_reg != delay_i) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule : mbd_mem_model

// >>> sim/memory_barrier_decode_test.sv
// Self-checking bench for the data order barrier decoder
`timescale 1ns/1ps
module memory_barrier_decode_test;
  logic clk_i = 1'b0, rst_n_i = 1'b0, instr_valid_i = 1'b0, compact_mode_i = 1'b0;
  logic hyp_present_i = 1'b0, secure_i = 1'b1, order_done_i;
  logic [31:0] instr_i = 32'h0;
  logic [1:0] priv_level_i = 2'h1, hyp_barrier_upgrade_i = 2'h0;
  logic [7:0] virtual_machine_tag_i = 8'h5a;
  logic [3:0] delay_i = 4'h0;
  logic barrier_req_o, access_stall_o, busy_o;
  mbd_pkg::mbd_req_t barrier_info_o;
  mbd_pkg::mbd_req_t min_info;
  int n_fail = 0, samples_checked = 0;
  always #2 clk_i = ~clk_i;
  mbd_decode i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .compact_mode_i(compact_mode_i), .hyp_present_i(hyp_present_i),
    .secure_i(secure_i), .priv_level_i(priv_level_i),
    .hyp_barrier_upgrade_i(hyp_barrier_upgrade_i),
    .virtual_machine_tag_i(virtual_machine_tag_i), .order_done_i(order_done_i),
    .barrier_req_o(barrier_req_o), .barrier_info_o(barrier_info_o),
    .access_stall_o(access_stall_o), .busy_o(busy_o));
  mbd_mem_model i_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .barrier_req_i(barrier_req_o),
    .delay_i(delay_i), .order_done_o(order_done_i));
  // Only the mandatory option supported; it tracks i_dut cycle for cycle, so it shares done
  mbd_decode #(.SUPPORTED_OPTS(16'h8000)) i_dut_min (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .compact_mode_i(compact_mode_i),
    .hyp_present_i(hyp_present_i), .secure_i(secure_i), .priv_level_i(priv_level_i),
    .hyp_barrier_upgrade_i(hyp_barrier_upgrade_i),
    .virtual_machine_tag_i(virtual_machine_tag_i), .order_done_i(order_done_i),
    .barrier_req_o(), .barrier_info_o(min_info), .access_stall_o(), .busy_o());
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_info(input mbd_pkg::mbd_req_t got, input mbd_pkg::mbd_req_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t info %h expected %h", $time, got, exp);
    end
  endtask : chk_info
  function automatic mbd_pkg::mbd_req_t exp_f(input logic [3:0] opt);
    mbd_pkg::mbd_req_t r;
    r.domain = mbd_pkg::MBD_DOM_FULL;
    r.types = mbd_pkg::MBD_TYP_ALL;
    if (opt[3:2] == 2'h0) r.domain = mbd_pkg::MBD_DOM_OUTER;
    if (opt[3:2] == 2'h1) r.domain = mbd_pkg::MBD_DOM_LOCAL;
    if (opt[3:2] == 2'h2) r.domain = mbd_pkg::MBD_DOM_INNER;
    if (opt[1:0] == 2'h2) r.types = mbd_pkg::MBD_TYP_WRITES;
    if (opt[1:0] == 2'h1) r.types = mbd_pkg::MBD_TYP_READS;
    if (opt[1:0] == 2'h0) r.domain = mbd_pkg::MBD_DOM_FULL;
    if (hyp_present_i && !secure_i && priv_level_i < 2'h2) begin
      if (hyp_barrier_upgrade_i == 2'h3) r.domain = mbd_pkg::MBD_DOM_FULL;
      if (hyp_barrier_upgrade_i == 2'h2 && r.domain != mbd_pkg::MBD_DOM_FULL)
        r.domain = mbd_pkg::MBD_DOM_OUTER;
    end
    r.order_wr_before = r.types != mbd_pkg::MBD_TYP_READS;
    r.order_rd_before = r.types != mbd_pkg::MBD_TYP_WRITES;
    r.hyp_scope = priv_level_i == 2'h2;
    r.vm_tag = r.hyp_scope ? 8'h00 : virtual_machine_tag_i;
    return r;
  endfunction : exp_f
  task automatic send(input logic [31:0] word, input logic cmp);
    instr_i = word;
    compact_mode_i = cmp;
    instr_valid_i = 1'b1;
    @(posedge clk_i);
    #1 instr_valid_i = 1'b0;
  endtask : send
  task automatic wait_idle;
    for (int n = 0; n < 40 && busy_o !== 1'b0; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk_bit(barrier_req_o, 1'b0);
    chk_bit(busy_o, 1'b0);
  endtask : wait_idle
  task automatic barrier(input logic [3:0] opt, input logic cmp);
    mbd_pkg::mbd_req_t e;
    e = exp_f(opt);
    send(cmp ? {28'hf3bf_8f5, opt} : {28'hf57f_f05, opt}, cmp);
    chk_bit(access_stall_o, 1'b1);
    chk_bit(busy_o, 1'b1);
    chk_info(barrier_info_o, e);
    chk_info(min_info, exp_f(4'hf));
    wait_idle();
  endtask : barrier
  task automatic t_refuse;
    mbd_pkg::mbd_req_t e;
    delay_i = 4'h8;
    e = exp_f(4'hb);
    send(32'hf3bf_8f5b, 1'b1);
    @(posedge clk_i);
    #1;
    send(32'hf3bf_8f57, 1'b1);
    chk_info(barrier_info_o, e);
    chk_bit(busy_o, 1'b1);
    wait_idle();
    barrier(4'h9, 1'b0);
    send(32'h157f_f05f, 1'b0);
    chk_bit(barrier_req_o, 1'b0);
    @(posedge clk_i);
    #1;
    send(32'hf57f_f04f, 1'b0);
    chk_bit(barrier_req_o, 1'b0);
    @(posedge clk_i);
    #1;
  endtask : t_refuse
  task automatic t_reset;
    delay_i = 4'h8;
    send(32'hf57f_f05b, 1'b0);
    rst_n_i = 1'b0;
    #1;
    chk_bit(busy_o, 1'b0);
    chk_bit(barrier_req_o, 1'b0);
    chk_bit(access_stall_o, 1'b0);
    chk_info(barrier_info_o, '0);
    @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    instr_valid_i = 1'b1;
    repeat (2) begin
      @(posedge clk_i);
      #1 chk_bit(busy_o, 1'b0);
    end
    @(posedge clk_i);
    #1 instr_valid_i = 1'b0;
    chk_bit(barrier_req_o, 1'b1);
    wait_idle();
  endtask : t_reset
  task automatic t_upgrade;
    for (int m = 0; m < 3; m++) begin
      hyp_present_i = m != 2;
      secure_i = m == 1;
      for (int p = 0; p < 3; p++) begin
        for (int u = 0; u < 4; u++) begin
          priv_level_i = 2'(p);
          hyp_barrier_upgrade_i = 2'(u);
          virtual_machine_tag_i = 8'(p * 16 + u + 1);
          delay_i = 4'(u);
          for (int k = 0; k < 3; k++) barrier(4'h7 + 4'(k * 3), k[0]);
        end
      end
    end
  endtask : t_upgrade
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    for (int o = 0; o < 32; o++) barrier(4'(o), o[4]);
    t_reset();
    t_refuse();
    t_upgrade();
    conclude();
  end
  initial begin
    #40000;
    n_fail++;
    conclude();
  end
endmodule : memory_barrier_decode_test
